// ---- pkg/irq_expansion_pkg.sv ----
package irq_expansion_pkg;
  // sizes of the request fabric
  localparam int NUM_REQ = 96;
  localparam int GRP_SIZE = 8;
  localparam int NUM_GRP = 12;
  localparam int USED_REQ = 43;
  localparam int NUM_EXT = 3;
  localparam int PORT_W = 32;
  localparam int SEL_W = 5;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STAT_W = 4;
  localparam int XCFG_W = 9;

  // cpu cycles spent on vector fetch plus context save
  localparam int CTX_CYCLES = 8;
  localparam logic [3:0] CTX_LOAD = 4'(CTX_CYCLES - 1);

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_GRP_ACK = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_XCFG_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_XSTAMP_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_XCNT_BASE = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_ENA_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_PEND_BASE = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_VEC_BASE = 12'h400;

  // field positions
  localparam int CTRL_GLOBAL_EN_BIT = 0;
  localparam int CTRL_NMI_ROUTE_BIT = 1;
  localparam int XCFG_MODE_LSB = 0;
  localparam int XCFG_EN_BIT = 2;
  localparam int XCFG_SEL_LSB = 4;
  localparam int STAT_FETCH_ERR_BIT = 3;

  // edge select encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // request slots fed by the first two external channels
  localparam int XINT_ONE_REQ = 3;
  localparam int XINT_TWO_REQ = 4;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [XCFG_W-1:0] XCFG_RST = 9'h000;
  localparam logic [GRP_SIZE-1:0] ENA_RST = 8'h00;
  localparam logic [STAT_W-1:0] MASK_RST = 4'h0;
endpackage

// ---- pkg/ext_irq_if.sv ----
`timescale 1ns/1ps
// carries one external channel's config, pin view and results
interface ext_irq_if;
  logic [irq_expansion_pkg::PORT_W-1:0] pins;
  logic [irq_expansion_pkg::SEL_W-1:0] sel;
  logic [1:0] mode;
  logic enable;
  logic edge_evt;
  logic [irq_expansion_pkg::CNT_W-1:0] count;
  logic [irq_expansion_pkg::CNT_W-1:0] stamp;

  modport ctrl (output pins, output sel, output mode, output enable, input edge_evt, input count, input stamp);
  modport chan (input pins, input sel, input mode, input enable, output edge_evt, output count, output stamp);
endinterface

// ---- verilog/external_irq_channel.sv ----
`timescale 1ns/1ps
module external_irq_channel (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  ext_irq_if.chan xif
);
  logic pin_now;
  logic prev_q;
  logic rise;
  logic fall;
  logic hit;
  logic [irq_expansion_pkg::CNT_W-1:0] cnt_q;
  logic [irq_expansion_pkg::CNT_W-1:0] stamp_q;
  logic evt_q;

  // source pin picked from the already synchronised port
  assign pin_now = xif.pins[xif.sel]; // RL12
  assign rise = pin_now & ~prev_q;
  assign fall = ~pin_now & prev_q;

  // edge qualification; changing sel may fake one edge
  always_comb
  begin
    case (xif.mode)
      irq_expansion_pkg::EDGE_FALL: hit = fall; // RL9
      irq_expansion_pkg::EDGE_RISE: hit = rise; // RL9
      default: hit = rise | fall; // RL9
    endcase
    hit = hit & xif.enable; // RL10
  end

  // previous pin level
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else
      prev_q <= pin_now;
  end

  // free-running stamp counter, cleared on a valid edge
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 16'h0000;
      stamp_q <= 16'h0000;
    end
    else if (hit)
    begin
      cnt_q <= 16'h0000; // RL11
      stamp_q <= cnt_q; // RL11
    end
    else
      cnt_q <= cnt_q + 16'h0001; // RL11
  end

  // one-cycle event pulse
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      evt_q <= 1'b0;
    else
      evt_q <= hit;
  end

  assign xif.edge_evt = evt_q;
  assign xif.count = cnt_q;
  assign xif.stamp = stamp_q;
endmodule // external_irq_channel

// ---- verilog/interrupt_expansion_unit.sv ----
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Function
// (RL1) Accept 96 peripheral request inputs and fold them onto fewer cpu lines.
// (RL2) Only 43 request inputs are live; the rest are forced inactive.
// (RL3) Eight requests form a group; each of twelve groups drives one cpu line.
// (RL4) Each request owns a vector word in a ram software may rewrite anytime.
// (RL5) Cpu fetches the vector on service; fetch plus context save take 8 cycles.
// (RL6) Each request has its own enable; disabled ones never reach their line.
// (RL7) Priority is fixed hardware order combined with software enables.
// (RL8) Three external channels; the third goes to line thirteen or nmi.
// (RL9) Each external channel triggers on falling, rising or both edges.
// (RL10) Each external channel, the nmi-capable one too, has an enable.
// (RL11) Each external channel has a 16-bit up counter cleared on a valid edge.
// (RL12) Channel source is selectable from any pin of the first gpio port.
// (RL13) Within a group the lowest-numbered pending enabled request goes first.
// (RL14) A forwarded group stays held off until software acknowledges it.
module interrupt_expansion_unit (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [irq_expansion_pkg::NUM_REQ-1:0] req_i,
  input wire logic [irq_expansion_pkg::PORT_W-1:0] porta_i,
  input wire logic cpu_fetch_i,
  input wire logic [3:0] cpu_fetch_line_i,
  input wire logic [irq_expansion_pkg::ADDR_W-1:0] addr_i,
  input wire logic [irq_expansion_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [irq_expansion_pkg::DATA_W-1:0] rd_data_o,
  output logic [irq_expansion_pkg::NUM_GRP-1:0] cpu_group_lines_o,
  output logic cpu_line_thirteen_o,
  output logic nmi_o,
  output logic [irq_expansion_pkg::DATA_W-1:0] vector_o,
  output logic vector_valid_o,
  output logic irq_o
);
  localparam int NR = irq_expansion_pkg::NUM_REQ;
  localparam int NG = irq_expansion_pkg::NUM_GRP;
  localparam int GS = irq_expansion_pkg::GRP_SIZE;
  localparam int NE = irq_expansion_pkg::NUM_EXT;
  localparam int DW = irq_expansion_pkg::DATA_W;
  localparam int SW = irq_expansion_pkg::STAT_W;

  logic [irq_expansion_pkg::PORT_W-1:0] porta_meta_q;
  logic [irq_expansion_pkg::PORT_W-1:0] porta_sync_q;
  logic [1:0] ctrl_q;
  logic [SW-1:0] stat_q;
  logic [SW-1:0] mask_q;
  logic [SW-1:0] stat_set;
  logic [SW-1:0] stat_clr;
  logic irq_q;
  logic [irq_expansion_pkg::XCFG_W-1:0] xcfg_q [NE];
  logic [GS-1:0] ena_q [NG];
  logic [DW-1:0] vec_mem [NR];
  logic [NE-1:0] evt;
  logic [irq_expansion_pkg::CNT_W-1:0] xcnt [NE];
  logic [irq_expansion_pkg::CNT_W-1:0] xstamp [NE];
  logic [1:0] xflag_q;
  logic [NR-1:0] live_mask;
  logic [NR-1:0] req_eff;
  logic busy_q [NG];
  logic line_q [NG];
  logic [2:0] idx_q [NG];
  logic [NG-1:0] ack_wr;
  logic [3:0] fetch_grp;
  logic fetch_ok;
  logic fetch_bad;
  logic [3:0] ctx_cnt_q;
  logic [6:0] vec_idx;
  logic [DW-1:0] vector_q;
  logic vector_valid_q;
  logic line13_q;
  logic nmi_q;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] rd_data_q;
  logic wr_ena;
  logic wr_vec;
  logic wr_xcfg;

  // pin synchroniser for the gpio port
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      porta_meta_q <= '0;
      porta_sync_q <= '0;
    end
    else
    begin
      porta_meta_q <= porta_i;
      porta_sync_q <= porta_meta_q;
    end
  end

  // external channels, one instance each
  ext_irq_if xif [NE] ();
  for (genvar c = 0; c < NE; c++)
  begin : g_ext
    assign xif[c].pins = porta_sync_q; // RL12
    assign xif[c].mode = xcfg_q[c][irq_expansion_pkg::XCFG_MODE_LSB +: 2];
    assign xif[c].enable = xcfg_q[c][irq_expansion_pkg::XCFG_EN_BIT];
    assign xif[c].sel = xcfg_q[c][irq_expansion_pkg::XCFG_SEL_LSB +: irq_expansion_pkg::SEL_W];
    assign evt[c] = xif[c].edge_evt;
    assign xcnt[c] = xif[c].count;
    assign xstamp[c] = xif[c].stamp;
    external_irq_channel u_chan (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .xif(xif[c])
    );
  end

  // write decodes
  assign wr_ena = wr_i && (addr_i[11:6] == irq_expansion_pkg::OFS_ENA_BASE[11:6]) && (addr_i[5:2] < 4'(NG));
  assign wr_vec = wr_i && (addr_i[11:10] == irq_expansion_pkg::OFS_VEC_BASE[11:10]) && (addr_i[8:2] < 7'(NR))
                  && !addr_i[9];
  assign wr_xcfg = wr_i && (addr_i[11:4] == irq_expansion_pkg::OFS_XCFG_BASE[11:4]) && (addr_i[3:2] < 2'(NE));
  assign ack_wr = (wr_i && addr_i == irq_expansion_pkg::OFS_GRP_ACK) ? wr_data_i[NG-1:0] : '0;

  // control, mask and channel configuration registers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= irq_expansion_pkg::CTRL_RST;
      mask_q <= irq_expansion_pkg::MASK_RST;
      for (int c = 0; c < NE; c++)
        xcfg_q[c] <= irq_expansion_pkg::XCFG_RST;
    end
    else
    begin
      if (wr_i && addr_i == irq_expansion_pkg::OFS_CTRL)
        ctrl_q <= wr_data_i[1:0];
      if (wr_i && addr_i == irq_expansion_pkg::OFS_IRQ_MASK)
        mask_q <= wr_data_i[SW-1:0];
      if (wr_xcfg)
        xcfg_q[addr_i[3:2]] <= wr_data_i[irq_expansion_pkg::XCFG_W-1:0];
    end
  end

  // per-request enables
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int g = 0; g < NG; g++)
        ena_q[g] <= irq_expansion_pkg::ENA_RST;
    end
    else if (wr_ena)
      ena_q[addr_i[5:2]] <= wr_data_i[GS-1:0]; // RL6
  end

  // vector ram, rewritable at any time, no reset
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_vec)
      vec_mem[addr_i[8:2]] <= wr_data_i; // RL4
  end

  // unused request slots are forced low
  for (genvar r = 0; r < NR; r++)
  begin : g_live
    assign live_mask[r] = (r < irq_expansion_pkg::USED_REQ); // RL2
  end

  // external channel one and two become requests in group one
  always_comb
  begin
    req_eff = req_i & live_mask; // RL1 RL2
    req_eff[irq_expansion_pkg::XINT_ONE_REQ] = req_eff[irq_expansion_pkg::XINT_ONE_REQ] | xflag_q[0];
    req_eff[irq_expansion_pkg::XINT_TWO_REQ] = req_eff[irq_expansion_pkg::XINT_TWO_REQ] | xflag_q[1];
  end

  // per-group forwarding, hold-off and lowest-first pick
  for (genvar g = 0; g < NG; g++)
  begin : g_grp
    logic [GS-1:0] pend;
    logic [2:0] first;
    assign pend = req_eff[g*GS +: GS] & ena_q[g]; // RL6 RL7
    always_comb
    begin
      first = 3'h0;
      for (int k = GS - 1; k >= 0; k--)
        if (pend[k])
          first = 3'(k); // RL13
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        busy_q[g] <= 1'b0;
        line_q[g] <= 1'b0;
        idx_q[g] <= 3'h0;
      end
      else if (ack_wr[g])
      begin
        busy_q[g] <= 1'b0; // RL14
        line_q[g] <= 1'b0;
      end
      else if (!busy_q[g] && ctrl_q[irq_expansion_pkg::CTRL_GLOBAL_EN_BIT] && |pend)
      begin
        busy_q[g] <= 1'b1; // RL14
        line_q[g] <= 1'b1; // RL3
        idx_q[g] <= first;
      end
      else if (fetch_ok && fetch_grp == 4'(g))
        line_q[g] <= 1'b0;
    end
    assign cpu_group_lines_o[g] = line_q[g]; // RL3
  end

  // external request latches, cleared once group one takes them; set wins
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      xflag_q <= 2'h0;
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (evt[c])
          xflag_q[c] <= 1'b1;
        else if (line_q[0] && !busy_q[0] == 1'b0 && idx_q[0] == 3'(irq_expansion_pkg::XINT_ONE_REQ + c))
          xflag_q[c] <= 1'b0;
      end
    end
  end

  // vector fetch: cpu names its line 1..12, one fetch per context window
  assign fetch_grp = cpu_fetch_line_i - 4'h1;
  assign fetch_ok = cpu_fetch_i && (ctx_cnt_q == 4'h0) && (cpu_fetch_line_i != 4'h0)
                    && (cpu_fetch_line_i <= 4'(NG)) && line_q[fetch_grp]; // RL5
  assign fetch_bad = cpu_fetch_i && !fetch_ok;
  assign vec_idx = {fetch_grp, idx_q[fetch_grp]};

  // vector answer and context-save window
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vector_q <= '0;
      vector_valid_q <= 1'b0;
      ctx_cnt_q <= 4'h0;
    end
    else
    begin
      vector_valid_q <= fetch_ok;
      if (fetch_ok)
      begin
        vector_q <= vec_mem[vec_idx]; // RL4 RL5
        ctx_cnt_q <= irq_expansion_pkg::CTX_LOAD; // RL5
      end
      else if (ctx_cnt_q != 4'h0)
        ctx_cnt_q <= ctx_cnt_q - 4'h1;
    end
  end

  // third channel routing to line thirteen or nmi
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line13_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      line13_q <= evt[2] & ~ctrl_q[irq_expansion_pkg::CTRL_NMI_ROUTE_BIT]; // RL8
      nmi_q <= evt[2] & ctrl_q[irq_expansion_pkg::CTRL_NMI_ROUTE_BIT]; // RL8
    end
  end

  // sticky status, write one to clear, set wins
  assign stat_set = {fetch_bad, evt};
  assign stat_clr = (wr_i && addr_i == irq_expansion_pkg::OFS_IRQ_STAT) ? wr_data_i[SW-1:0] : '0;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read decode
  always_comb
  begin
    rd_val = '0;
    if (addr_i == irq_expansion_pkg::OFS_CTRL)
      rd_val[1:0] = ctrl_q;
    else if (addr_i == irq_expansion_pkg::OFS_GRP_ACK)
      for (int g = 0; g < NG; g++)
        rd_val[g] = busy_q[g];
    else if (addr_i == irq_expansion_pkg::OFS_IRQ_STAT)
      rd_val[SW-1:0] = stat_q;
    else if (addr_i == irq_expansion_pkg::OFS_IRQ_MASK)
      rd_val[SW-1:0] = mask_q;
    else if (addr_i[11:4] == irq_expansion_pkg::OFS_XCFG_BASE[11:4] && addr_i[3:2] < 2'(NE))
      rd_val[irq_expansion_pkg::XCFG_W-1:0] = xcfg_q[addr_i[3:2]];
    else if (addr_i[11:4] == irq_expansion_pkg::OFS_XSTAMP_BASE[11:4] && addr_i[3:2] < 2'(NE))
      rd_val[15:0] = xstamp[addr_i[3:2]];
    else if (addr_i[11:4] == irq_expansion_pkg::OFS_XCNT_BASE[11:4] && addr_i[3:2] < 2'(NE))
      rd_val[15:0] = xcnt[addr_i[3:2]];
    else if (addr_i[11:6] == irq_expansion_pkg::OFS_ENA_BASE[11:6] && addr_i[5:2] < 4'(NG))
      rd_val[GS-1:0] = ena_q[addr_i[5:2]];
    else if (addr_i[11:6] == irq_expansion_pkg::OFS_PEND_BASE[11:6] && addr_i[5:2] < 4'(NG))
      rd_val[GS-1:0] = req_eff[addr_i[5:2]*GS +: GS];
    else if (addr_i[11:10] == irq_expansion_pkg::OFS_VEC_BASE[11:10] && !addr_i[9] && addr_i[8:2] < 7'(NR))
      rd_val = vec_mem[addr_i[8:2]];
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_q <= '0;
    else
      rd_data_q <= rd_i ? rd_val : '0;
  end

  assign rd_data_o = rd_data_q;
  assign cpu_line_thirteen_o = line13_q;
  assign nmi_o = nmi_q;
  assign vector_o = vector_q;
  assign vector_valid_o = vector_valid_q;
  assign irq_o = irq_q;
endmodule // interrupt_expansion_unit

// ---- verification/irq_expansion_asserts.sv ----
`timescale 1ns/1ps
module irq_expansion_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [95:0] req_i,
  input wire logic cpu_fetch_i,
  input wire logic [3:0] cpu_fetch_line_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [11:0] cpu_group_lines_o,
  input wire logic cpu_line_thirteen_o,
  input wire logic nmi_o,
  input wire logic vector_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // the fetch window keeps the vector strobe quiet
  sequence s_quiet;
    !vector_valid_o [*7];
  endsequence
  sequence s_accept;
    $past(cpu_fetch_i) && $past(cpu_fetch_line_i) inside {[4'd1:4'd12]};
  endsequence

  property p_rd_idle;
    !$past(rd_i) |-> rd_data_o == 32'h0;
  endproperty
  property p_fetch_cause;
    vector_valid_o |-> s_accept;
  endproperty
  property p_window;
    vector_valid_o |=> s_quiet;
  endproperty
  property p_unused;
    cpu_group_lines_o[11:6] == 6'h0;
  endproperty
  property p_rise_cause;
    $rose(cpu_group_lines_o[1]) |-> $past(|req_i[15:8]);
  endproperty
  property p_hold;
    cpu_group_lines_o[1] && !cpu_fetch_i && !wr_i |=> cpu_group_lines_o[1];
  endproperty
  property p_ack;
    wr_i && addr_i == 12'h004 && wr_data_i[1] |=> !cpu_group_lines_o[1];
  endproperty
  property p_served;
    vector_valid_o && $past(cpu_fetch_line_i) == 4'd2 |-> !cpu_group_lines_o[1];
  endproperty
  property p_route;
    !(nmi_o && cpu_line_thirteen_o);
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_fetch_cause: assert property (p_fetch_cause) else $error("vector without fetch");
  a_window: assert property (p_window) else $error("fetch window broken");
  a_unused: assert property (p_unused) else $error("unused line active");
  a_rise_cause: assert property (p_rise_cause) else $error("line without request");
  a_hold: assert property (p_hold) else $error("line dropped early");
  a_ack: assert property (p_ack) else $error("ack left line high");
  a_served: assert property (p_served) else $error("line high after fetch");
  a_route: assert property (p_route) else $error("both routes pulsed");
endmodule // irq_expansion_asserts

bind interrupt_expansion_unit irq_expansion_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .req_i(req_i), .cpu_fetch_i(cpu_fetch_i), .cpu_fetch_line_i(cpu_fetch_line_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .cpu_group_lines_o(cpu_group_lines_o), .cpu_line_thirteen_o(cpu_line_thirteen_o), .nmi_o(nmi_o),
  .vector_valid_o(vector_valid_o));

// ---- verification/cpu_core_model.sv ----
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] lines_i,
  input wire logic [3:0] wait_i,
  output logic fetch_o,
  output logic [3:0] line_o
);
  logic [4:0] gap_q;
  logic [3:0] pick;

  // lowest raised line is serviced first
  always_comb
  begin
    pick = 4'h0;
    for (int g = 11; g >= 0; g--)
      if (lines_i[g])
        pick = 4'(g + 1);
  end

  // one fetch pulse, then the context save keeps it quiet; line toggles when unqualified
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      fetch_o <= 1'b0;
      line_o <= 4'h0;
      gap_q <= 5'h0;
    end
    else if (gap_q == 5'h0 && pick != 4'h0)
    begin
      fetch_o <= 1'b1;
      line_o <= pick;
      gap_q <= 5'(8 + wait_i);
    end
    else
    begin
      fetch_o <= 1'b0;
      line_o <= ~line_o;
      gap_q <= (gap_q == 5'h0) ? 5'h0 : gap_q - 5'h1;
    end
endmodule // cpu_core_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [95:0] req = '0;
  logic [31:0] porta = '0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] slow = '0;
  logic fetch, irq, l13, nmi, vv, rd_prev;
  logic [3:0] fline;
  logic [11:0] lines;
  logic [31:0] rdata, vec, ex;
  logic [31:0] rd_q[$], rd_m[$], vec_q[$], vram[96];
  logic [7:0] r;
  int err_count = 0, checks_done = 0, cyc = 0, p13 = 0, pn = 0, e13 = 0, en = 0, n, p;

  always #10 sys_clk_i = ~sys_clk_i;

  interrupt_expansion_unit DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .porta_i(porta),
    .cpu_fetch_i(fetch), .cpu_fetch_line_i(fline), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdata), .cpu_group_lines_o(lines), .cpu_line_thirteen_o(l13), .nmi_o(nmi), .vector_o(vec),
    .vector_valid_o(vv), .irq_o(irq));
  cpu_core_model u_cpu (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lines_i(lines), .wait_i(slow),
    .fetch_o(fetch), .line_o(fline));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd32(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk_i);
    rd <= 1'b1;
    addr <= a;
    rd_q.push_back(e);
    rd_m.push_back(m);
    @(posedge sys_clk_i);
    rd <= 1'b0;
  endtask

  task automatic wait_vec();
    repeat (300)
      if (vec_q.size() != 0)
        @(posedge sys_clk_i);
    chk(32'(vec_q.size()), 32'h0);
  endtask

  // monitor: read data one cycle after the strobe, vectors on the valid pulse
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (rd_prev === 1'b1)
      chk(rdata & rd_m.pop_front(), rd_q.pop_front());
    rd_prev = rd;
    if (vv === 1'b1)
      chk(vec, vec_q.pop_front());
    p13 += int'(l13 === 1'b1);
    pn += int'(nmi === 1'b1);
    if (cyc > 40000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hdabb));
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (vram[i])
      vram[i] = '0;
    rd32(12'h000, 32'h0, 32'hffffffff);
    rd32(12'h00c, 32'h0, 32'hffffffff);
    rd32(12'h010, 32'h0, 32'hffffffff);
    rd32(12'h040, 32'h0, 32'hffffffff);
    rd32(12'h3fc, 32'h0, 32'hffffffff);
    for (int i = 0; i < 48; i++)
    begin
      vram[i] = $urandom;
      wr32(12'h400 + 12'(4 * i), vram[i]);
    end
    rd32(12'h424, vram[9], 32'hffffffff);
    for (int g = 0; g < 6; g++)
      wr32(12'h040 + 12'(4 * g), 32'hff);
    wr32(12'h000, 32'h1);
    // several pending in one group: lowest first, held until ack
    r = 8'($urandom) | 8'h81;
    req[15:8] <= r;
    for (int i = 0; i < 8; i++)
      if (r[i])
      begin
        vec_q.push_back(vram[8 + i]);
        wait_vec();
        req[8 + i] <= 1'b0;
        wr32(12'h004, 32'h2);
      end
    // a disabled request stays off its line until enabled
    wr32(12'h048, 32'hfe);
    req[16] <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    chk(32'(lines), 32'h0);
    req[17] <= 1'b1;
    vec_q.push_back(vram[17]);
    wait_vec();
    req[17] <= 1'b0;
    wr32(12'h004, 32'h4);
    vec_q.push_back(vram[16]);
    wr32(12'h048, 32'hff);
    wait_vec();
    req[16] <= 1'b0;
    wr32(12'h004, 32'h4);
    // each live group reaches its own line; vectors rewritten on the fly
    for (int g = 0; g < 6; g++)
    begin
      n = g * 8 + $urandom % 3;
      slow <= 4'($urandom % 10);
      vram[n] = $urandom;
      wr32(12'h400 + 12'(4 * n), vram[n]);
      vec_q.push_back(vram[n]);
      req[n] <= 1'b1;
      wait_vec();
      req[n] <= 1'b0;
      wr32(12'h004, 32'(1 << g));
    end
    wr32(12'h058, 32'hff);
    req[50] <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    chk(32'(lines), 32'h0);
    req[50] <= 1'b0;
    // external channels: every edge kind, enable, pin and route
    wr32(12'h040, 32'he7);
    wr32(12'h00c, 32'h7);
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 3; m++)
      begin
        p = $urandom % 32;
        wr32(12'h000, {30'h0, m[0], 1'b1});
        wr32(12'h010 + 12'(4 * c), 32'(p << 4 | 4 | m));
        repeat (5) @(posedge sys_clk_i);
        wr32(12'h008, 32'h7);
        for (int e = 1; e >= 0; e--)
        begin
          porta[p] <= e[0];
          repeat (8) @(posedge sys_clk_i);
          ex = (m == 2 || m == e) ? 32'h1 : 32'h0;
          e13 += int'(c == 2 && ex[0] && !m[0]);
          en += int'(c == 2 && ex[0] && m[0]);
          chk(32'(irq), ex);
          rd32(12'h008, ex << c, 32'h7);
          if (ex[0])
            rd32(12'h030 + 12'(4 * c), 32'h0, 32'hffffff00);
          wr32(12'h008, 32'h7);
        end
        // park the channel so a later random pin cannot wake it
        if (m == 2)
          wr32(12'h010 + 12'(4 * c), 32'h0);
      end
    chk(32'(p13), 32'(e13));
    chk(32'(pn), 32'(en));
    // masked event sets status only; disabled channel stays silent
    wr32(12'h00c, 32'h0);
    wr32(12'h010, 32'h011);
    wr32(12'h014, 32'h025);
    repeat (5) @(posedge sys_clk_i);
    wr32(12'h008, 32'h7);
    porta[1] <= 1'b1;
    porta[2] <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk(32'(irq), 32'h0);
    rd32(12'h008, 32'h2, 32'hf);
    repeat (3) @(posedge sys_clk_i);
    report_and_stop();
  end
endmodule // tb_top
